/* shared/rtm_pkg.sv */
// Package: offsets, layouts, restore values and enumerations for the reference trim and margin registers
package rtm_pkg;

  // ==========================================================================
  // Command codes of the three offset registers
  // ==========================================================================
  localparam logic [7:0] RTM_CMD_TRIM = 8'hd4;        // Reference trim offset
  localparam logic [7:0] RTM_CMD_MARGIN_UP = 8'hd5;   // Margin-up step offset
  localparam logic [7:0] RTM_CMD_MARGIN_DN = 8'hd6;   // Margin-down step offset

  // ==========================================================================
  // Reset and restore values
  // ==========================================================================
  localparam logic [15:0] RTM_TRIM_RST = 16'h0000;    // Trim default
  localparam logic [15:0] RTM_MUP_RST0 = 16'h0009;    // Margin-up restore, select clear
  localparam logic [15:0] RTM_MUP_RST1 = 16'h000f;    // Margin-up restore, select set
  localparam logic [15:0] RTM_MDN_RST0 = 16'hfff7;    // Margin-down restore, select clear
  localparam logic [15:0] RTM_MDN_RST1 = 16'hfff1;    // Margin-down restore, select set

  // ==========================================================================
  // Code ranges, in steps of 2^-9 V
  // ==========================================================================
  localparam logic signed [15:0] RTM_TRIM_MIN = -16'sd64;   // Lowest trim code
  localparam logic signed [15:0] RTM_TRIM_MAX = 16'sd63;    // Highest trim code
  localparam logic signed [15:0] RTM_MUP_MIN = 16'sd0;      // Lowest margin-up code
  localparam logic signed [15:0] RTM_MUP_MAX = 16'sd31;     // Highest margin-up code
  localparam logic signed [15:0] RTM_MDN_MIN = -16'sd64;    // Lowest margin-down code
  localparam logic signed [15:0] RTM_MDN_MAX = -16'sd1;     // Highest margin-down code

  // ==========================================================================
  // Fixed output-voltage format
  // ==========================================================================
  localparam logic [7:0] RTM_VOUT_MODE = 8'h17;       // Linear mode, exponent -9 in 5-bit two's complement
  localparam int RTM_REF_W = 16;                      // Width of reference words

  // ==========================================================================
  // Operating states and operation selects
  // ==========================================================================
  typedef enum logic [1:0]
  {
    RTM_ST_SOFT_START = 2'b00,
    RTM_ST_STEADY = 2'b01,
    RTM_ST_TOFF_DELAY = 2'b10,
    RTM_ST_SOFT_STOP = 2'b11
  } rtm_state_t;

  typedef enum logic [1:0]
  {
    RTM_OP_NOMINAL = 2'b00,
    RTM_OP_MARGIN_LOW = 2'b01,
    RTM_OP_MARGIN_HIGH = 2'b10
  } rtm_margin_t;

  // Byte-transfer phase of a word access
  typedef enum logic [1:0]
  {
    RTM_PH_IDLE = 2'b00,
    RTM_PH_LOW = 2'b01,
    RTM_PH_HIGH = 2'b10
  } rtm_phase_t;

endpackage : rtm_pkg

/* src/rtm_regs.sv */
// Module: reference trim and margin step offset registers with clamping, refusal and ramped reference
`timescale 1ns/1ps
module rtm_regs
  import rtm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Command byte port from the serial engine
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic wr_byte_i,
  input wire logic rd_byte_i,
  input wire logic [7:0] wr_data_i,
  input wire logic cmd_end_i,
  output logic [7:0] rd_data_o,
  output logic nack_o,
  // Device configuration
  input wire logic loop_slave_i,
  input wire logic margin_up_restore_select_i,
  input wire logic margin_down_restore_select_i,
  input wire logic restore_i,
  input wire logic store_all_i,
  input wire logic [1:0] operation_margin_i,
  input wire logic [1:0] op_state_i,
  // Reference setting and limits
  input wire logic [15:0] vout_command_i,
  input wire logic [15:0] vout_max_i,
  input wire logic [15:0] vout_min_i,
  input wire logic [15:0] ton_rise_step_i,
  input wire logic [15:0] transition_step_i,
  input wire logic [15:0] toff_fall_step_i,
  // Status and outputs
  output logic invalid_command_fault_o,
  output logic communication_fault_bit_o,
  output logic invalid_data_o,
  output logic smbalert_o,
  output logic nv_save_o,
  output logic [15:0] nv_trim_o,
  output logic [7:0] vout_mode_o,
  output logic [15:0] loop_reference_voltage_o
);

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [15:0] trim_r;              // Trim word as stored
  logic [15:0] mup_r;               // Margin-up word
  logic [15:0] mdn_r;               // Margin-down word
  logic [7:0] low_r;                // Low byte held until the high byte arrives
  rtm_phase_t wph_r;                // Write byte phase
  rtm_phase_t rph_r;                // Read byte phase
  logic [7:0] rd_data_r;
  logic nack_r;
  logic ivc_r;
  logic cml_r;
  logic inv_r;
  logic alert_r;
  logic nv_save_r;
  logic [15:0] nv_trim_r;
  logic [15:0] ref_r;               // Ramped reference

  // ==========================================================================
  // Decode
  // ==========================================================================
  wire sel_trim = cmd_valid_i && (cmd_code_i == RTM_CMD_TRIM);
  wire sel_mup = cmd_valid_i && (cmd_code_i == RTM_CMD_MARGIN_UP);
  wire sel_mdn = cmd_valid_i && (cmd_code_i == RTM_CMD_MARGIN_DN);
  wire sel_any = sel_trim || sel_mup || sel_mdn;
  wire refuse = sel_any && loop_slave_i && (wr_byte_i || rd_byte_i);
  wire take_wr = sel_any && !loop_slave_i && wr_byte_i;
  wire take_rd = sel_any && !loop_slave_i && rd_byte_i;
  wire wr_word = take_wr && (wph_r == RTM_PH_HIGH);

  // Full written word, low byte first, then high byte
  wire [15:0] word_w = {wr_data_i, low_r};
  wire signed [15:0] sword = $signed(word_w);

  // Range limits of the addressed register
  wire signed [15:0] lim_lo = sel_trim ? RTM_TRIM_MIN : (sel_mup ? RTM_MUP_MIN : RTM_MDN_MIN);
  wire signed [15:0] lim_hi = sel_trim ? RTM_TRIM_MAX : (sel_mup ? RTM_MUP_MAX : RTM_MDN_MAX);
  wire too_low = sword < lim_lo;
  wire too_high = sword > lim_hi;
  wire out_range = wr_word && (too_low || too_high);
  wire [15:0] clamped = too_low ? lim_lo : (too_high ? lim_hi : word_w);

  // Writable bits only, high byte rebuilt as sign extension
  wire [15:0] trim_w = {{8{clamped[15]}}, clamped[7:0]};
  wire [15:0] mup_w = {11'h000, clamped[4:0]};
  wire [15:0] mdn_w = {{10{clamped[15]}}, clamped[5:0]};

  // Restore values chosen by option bits
  wire [15:0] mup_rst = margin_up_restore_select_i ? RTM_MUP_RST1 : RTM_MUP_RST0;
  wire [15:0] mdn_rst = margin_down_restore_select_i ? RTM_MDN_RST1 : RTM_MDN_RST0;

  // Read word and byte select
  wire [15:0] rd_word = sel_trim ? trim_r : (sel_mup ? mup_r : mdn_r);
  wire [7:0] rd_byte = (rph_r == RTM_PH_HIGH) ? rd_word[15:8] : rd_word[7:0];

  // ==========================================================================
  // Reference target: command plus trim plus margin, then bounded
  // ==========================================================================
  wire signed [17:0] sum_w = $signed({2'b00, vout_command_i}) + $signed({{2{trim_r[15]}}, trim_r})
    + ((operation_margin_i == RTM_OP_MARGIN_HIGH) ? $signed({{2{mup_r[15]}}, mup_r}) : 18'sd0)
    + ((operation_margin_i == RTM_OP_MARGIN_LOW) ? $signed({{2{mdn_r[15]}}, mdn_r}) : 18'sd0);
  wire signed [17:0] vmax_s = $signed({2'b00, vout_max_i});
  wire signed [17:0] vmin_s = $signed({2'b00, vout_min_i});
  wire [15:0] target = (sum_w > vmax_s) ? vout_max_i :
                       ((sum_w < vmin_s) ? vout_min_i : sum_w[15:0]);

  // Step size per operating state
  wire [15:0] step = (op_state_i == RTM_ST_SOFT_START) ? ton_rise_step_i :
                     ((op_state_i == RTM_ST_SOFT_STOP) ? toff_fall_step_i : transition_step_i);
  wire [16:0] up_sum = {1'b0, ref_r} + {1'b0, step};
  wire [15:0] up_ref = (up_sum[16] || (up_sum[15:0] > target)) ? target : up_sum[15:0];
  wire [15:0] dn_ref = ((ref_r - target) < step) ? target : (ref_r - step);
  wire [15:0] ref_nxt = (ref_r < target) ? up_ref : ((ref_r > target) ? dn_ref : ref_r);

  // ==========================================================================
  // Byte phase tracking: low byte first, high byte second
  // ==========================================================================
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i || cmd_end_i)
    begin
      wph_r <= RTM_PH_LOW;
      rph_r <= RTM_PH_LOW;
      low_r <= 8'h00;
    end
    else
    begin
      // Capture low byte, then expect the high byte
      if (take_wr && wph_r == RTM_PH_LOW)
      begin
        low_r <= wr_data_i;
        wph_r <= RTM_PH_HIGH;
      end
      else if (wr_word)
        wph_r <= RTM_PH_IDLE;
      // Advance the read pointer per byte
      if (take_rd)
        rph_r <= (rph_r == RTM_PH_LOW) ? RTM_PH_HIGH : RTM_PH_IDLE;
    end
  end

  // ==========================================================================
  // Offset registers
  // ==========================================================================
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      trim_r <= RTM_TRIM_RST;
      mup_r <= RTM_MUP_RST0;
      mdn_r <= RTM_MDN_RST0;
    end
    else if (restore_i)
    begin
      // Margin words take option-selected values; trim reloads its saved copy
      trim_r <= nv_trim_r;
      mup_r <= mup_rst;
      mdn_r <= mdn_rst;
    end
    else if (wr_word)
    begin
      if (sel_trim)
        trim_r <= trim_w;
      if (sel_mup)
        mup_r <= mup_w;
      if (sel_mdn)
        mdn_r <= mdn_w;
    end
  end

  // ==========================================================================
  // Nonvolatile copy of the trim word
  // ==========================================================================
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      nv_trim_r <= RTM_TRIM_RST;
      nv_save_r <= 1'b0;
    end
    else
    begin
      nv_save_r <= store_all_i;
      if (store_all_i)
        nv_trim_r <= trim_r;
    end
  end

  // ==========================================================================
  // Read data, refusal and fault flags; new events win over clear
  // ==========================================================================
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      rd_data_r <= 8'h00;
      nack_r <= 1'b0;
      ivc_r <= 1'b0;
      cml_r <= 1'b0;
      inv_r <= 1'b0;
      alert_r <= 1'b0;
    end
    else
    begin
      rd_data_r <= take_rd ? rd_byte : 8'h00;
      nack_r <= refuse;
      // Flags stay until a restore; a fault in the same cycle still sets them
      ivc_r <= refuse || (ivc_r && !restore_i);
      inv_r <= out_range || (inv_r && !restore_i);
      cml_r <= refuse || out_range || (cml_r && !restore_i);
      alert_r <= refuse || out_range || (alert_r && !restore_i);
    end
  end

  // ==========================================================================
  // Ramped reference
  // ==========================================================================
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
      ref_r <= 16'h0000;
    else
      ref_r <= ref_nxt;
  end

  // Output mode byte is a constant register image
  logic [7:0] mode_r;
  always_ff @(posedge ref_clk_i)
  begin
    mode_r <= RTM_VOUT_MODE;
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign rd_data_o = rd_data_r;
  assign nack_o = nack_r;
  assign invalid_command_fault_o = ivc_r;
  assign communication_fault_bit_o = cml_r;
  assign invalid_data_o = inv_r;
  assign smbalert_o = alert_r;
  assign nv_save_o = nv_save_r;
  assign nv_trim_o = nv_trim_r;
  assign vout_mode_o = mode_r;
  assign loop_reference_voltage_o = ref_r;

endmodule : rtm_regs

/* verif/rtm_regs_sva.sv */
// Checker: port-level properties of the reference trim and margin registers
`timescale 1ns/1ps
module rtm_regs_chk
  import rtm_pkg::*;
(
  // Clock, reset and command port
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic wr_byte_i,
  input wire logic rd_byte_i,
  // Configuration
  input wire logic loop_slave_i,
  input wire logic restore_i,
  input wire logic store_all_i,
  input wire logic [1:0] op_state_i,
  input wire logic [15:0] transition_step_i,
  // Outputs watched
  input wire logic [7:0] rd_data_o,
  input wire logic nack_o,
  input wire logic invalid_command_fault_o,
  input wire logic communication_fault_bit_o,
  input wire logic invalid_data_o,
  input wire logic smbalert_o,
  input wire logic nv_save_o,
  input wire logic [7:0] vout_mode_o,
  input wire logic [15:0] loop_reference_voltage_o
);
  // ==========================================================================
  // Helpers
  // ==========================================================================
  // A byte taken for one of the three offset commands
  wire logic hit = cmd_valid_i && (wr_byte_i || rd_byte_i) &&
                   (cmd_code_i >= RTM_CMD_TRIM) && (cmd_code_i <= RTM_CMD_MARGIN_DN);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_refuse_nack: assert property (hit && loop_slave_i |=> nack_o)
    else $error("refused byte not nacked");
  a_refuse_flags: assert property (hit && loop_slave_i |=> invalid_command_fault_o && smbalert_o)
    else $error("refusal flags missing");
  a_nack_cause: assert property (nack_o |-> $past(hit && loop_slave_i))
    else $error("nack without refusal");
  a_mode_fixed: assert property (vout_mode_o == RTM_VOUT_MODE)
    else $error("format byte changed");
  a_save_pulse: assert property (store_all_i |=> nv_save_o)
    else $error("store not signalled");
  a_cml_sticky: assert property (communication_fault_bit_o && !restore_i |=> communication_fault_bit_o)
    else $error("fault bit dropped");
  a_invalid_alert: assert property ($rose(invalid_data_o) |-> smbalert_o && communication_fault_bit_o)
    else $error("clamp flags apart");
  a_read_idle: assert property (!(hit && rd_byte_i) |=> rd_data_o == 8'h00)
    else $error("read data without request");
  a_ramp_steady: assert property (op_state_i == RTM_ST_STEADY |=>
    ({1'b0, loop_reference_voltage_o} <= {1'b0, $past(loop_reference_voltage_o)} + $past(transition_step_i)) &&
    ({1'b0, loop_reference_voltage_o} + $past(transition_step_i) >= {1'b0, $past(loop_reference_voltage_o)}))
    else $error("reference stepped too far");
  // Main scenarios reached
  c_refused: cover property (nack_o);
  c_clamped: cover property ($rose(invalid_data_o));
  c_restored: cover property (restore_i && communication_fault_bit_o);
endmodule : rtm_regs_chk

/* verif/rtm_host.sv */
// Host model: word transfers to the command byte port, driven on the falling edge
`timescale 1ns/1ps
module rtm_host
(
  // Clock and answers
  input wire logic ref_clk_i,
  input wire logic [7:0] rd_data_i,
  input wire logic nack_i,
  // Command byte requests
  output logic cmd_valid_o = 1'b0,
  output logic [7:0] cmd_code_o = 8'h00,
  output logic wr_byte_o = 1'b0,
  output logic rd_byte_o = 1'b0,
  output logic [7:0] wr_data_o = 8'h00,
  output logic cmd_end_o = 1'b0
);
  // One word transfer: low byte, then high byte, then stop; collects read data and nack
  task automatic xfer(input logic [7:0] code, input logic wr, input logic [15:0] wd, output logic [15:0] rdw,
                      output logic nk);
    nk = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      @(negedge ref_clk_i);
      if (i == 1)
      begin
        rdw[7:0] = rd_data_i;
        nk = nk | nack_i;
      end
      cmd_valid_o <= 1'b1;
      cmd_code_o <= code;
      wr_byte_o <= wr;
      rd_byte_o <= !wr;
      wr_data_o <= wd[8*i +: 8];
    end
    @(negedge ref_clk_i);
    rdw[15:8] = rd_data_i;
    nk = nk | nack_i;
    wr_byte_o <= 1'b0;
    rd_byte_o <= 1'b0;
    cmd_end_o <= 1'b1;
    @(negedge ref_clk_i);
    cmd_end_o <= 1'b0;
    cmd_valid_o <= 1'b0;
    wr_data_o <= ~wr_data_o;
  endtask : xfer
endmodule : rtm_host

/* verif/tb_top.sv */
// Testbench: register accesses, clamping, save and restore, reference and refusal
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import rtm_pkg::*;
  // Stimulus and observed signals
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic slave = 1'b0, mup_sel = 1'b0, mdn_sel = 1'b0, restore = 1'b0, store_all = 1'b0;
  logic [1:0] op = 2'b00, st = 2'b01;
  logic [15:0] vcmd = 16'h0100, vmax = 16'hffff, vmin = 16'h0000, step = 16'hffff;
  // Soft-start and soft-stop steps, kept apart from the transition step
  logic [15:0] step_on = 16'hffff, step_off = 16'hffff;
  logic cv, wb, rb, ce, nack, invalid_command_fault, communication_fault_bit, inv, alert, nvs, nk;
  logic [7:0] code, wd, rd, mode;
  logic [15:0] nvt, lref, rw;
  int err_count = 0, total_checks = 0;
  // Write and read tables: command, value written, value read back
  logic [7:0] t_code [11] = '{8'hd4, 8'hd4, 8'hd4, 8'hd4, 8'hd5, 8'hd5, 8'hd5, 8'hd6, 8'hd6, 8'hd6, 8'hd6};
  logic [15:0] t_wr [11] = '{16'hffc0, 16'h003f, 16'h0040, 16'hff00, 16'h001f, 16'h0020, 16'hffff, 16'hffc0, 16'hffff,
                              16'h0000, 16'hff00};
  logic [15:0] t_ex [11] = '{16'hffc0, 16'h003f, 16'h003f, 16'hffc0, 16'h001f, 16'h001f, 16'h0000, 16'hffc0, 16'hffff,
                              16'hffff, 16'hffc0};
  // Clock at 4 ns
  initial forever #2 ref_clk_i = ~ref_clk_i;
  rtm_host host (.ref_clk_i(ref_clk_i), .rd_data_i(rd), .nack_i(nack), .cmd_valid_o(cv), .cmd_code_o(code),
                 .wr_byte_o(wb), .rd_byte_o(rb), .wr_data_o(wd), .cmd_end_o(ce));
  rtm_regs uut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .cmd_valid_i(cv), .cmd_code_i(code), .wr_byte_i(wb),
                .rd_byte_i(rb), .wr_data_i(wd), .cmd_end_i(ce), .rd_data_o(rd), .nack_o(nack), .loop_slave_i(slave),
                .margin_up_restore_select_i(mup_sel), .margin_down_restore_select_i(mdn_sel), .restore_i(restore),
                .store_all_i(store_all), .operation_margin_i(op), .op_state_i(st), .vout_command_i(vcmd),
                .vout_max_i(vmax), .vout_min_i(vmin), .ton_rise_step_i(step_on), .transition_step_i(step),
                .toff_fall_step_i(step_off), .invalid_command_fault_o(invalid_command_fault), .communication_fault_bit_o(communication_fault_bit),
                .invalid_data_o(inv), .smbalert_o(alert), .nv_save_o(nvs), .nv_trim_o(nvt), .vout_mode_o(mode),
                .loop_reference_voltage_o(lref));
  // Word access helpers
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    host.xfer(c, 1'b1, d, rw, nk);
  endtask : wr
  task automatic chk_rd(input logic [7:0] c, input logic [15:0] e);
    host.xfer(c, 1'b0, 16'h0000, rw, nk);
    `CHK("read word", e, rw)
  endtask : chk_rd
  // Counts and verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // Hang guard, well beyond the few hundred cycles the tests need
  initial
  begin
    #(20000 * 4);
    err_count++;
    summarize();
  end
  // Test sequence
  initial
  begin
    repeat (16) @(negedge ref_clk_i);
    resetn_i <= 1'b1;
    chk_rd(8'hd4, 16'h0000);
    chk_rd(8'hd5, 16'h0009);
    chk_rd(8'hd6, 16'hfff7);
    `CHK("format", 8'h17, mode)
    $display("test reset values done");
    for (int i = 0; i < 11; i++)
    begin
      wr(t_code[i], t_wr[i]);
      chk_rd(t_code[i], t_ex[i]);
      if (i == 1)
        `CHK("fault before clamp", 1'b0, communication_fault_bit)
    end
    `CHK("flags after clamp", 3'b111, {communication_fault_bit, inv, alert})
    $display("test ranges done");
    for (int s = 0; s < 2; s++)
    begin
      wr(8'hd4, 16'h0005 + s);
      @(negedge ref_clk_i) store_all <= 1'b1;
      @(negedge ref_clk_i) store_all <= 1'b0;
      repeat (2) @(negedge ref_clk_i);
      `CHK("saved trim", 16'h0005 + s, nvt)
      wr(8'hd4, 16'h0002);
      mup_sel <= s[0];
      mdn_sel <= s[0];
      @(negedge ref_clk_i) restore <= 1'b1;
      @(negedge ref_clk_i) restore <= 1'b0;
      chk_rd(8'hd4, 16'h0005 + s);
      chk_rd(8'hd5, s ? 16'h000f : 16'h0009);
      chk_rd(8'hd6, s ? 16'hfff1 : 16'hfff7);
      `CHK("flags after restore", 2'b00, {communication_fault_bit, inv})
    end
    $display("test save and restore done");
    for (int m = 0; m < 3; m++)
    begin
      op <= m[1:0];
      repeat (8) @(negedge ref_clk_i);
      `CHK("reference", (m == 0) ? 16'h0106 : (m == 1) ? 16'h00f7 : 16'h0115, lref)
    end
    vmax <= 16'h0110;
    vmin <= 16'h00fc;
    step_on <= 16'h0002;
    step <= 16'h0001;
    step_off <= 16'h0004;
    for (int s = 0; s < 4; s++)
    begin
      st <= s[1:0];
      op <= s[0] ? 2'b10 : 2'b01;
      // Four edges in: the distance moved shows which step the state picked
      repeat (4) @(negedge ref_clk_i);
      `CHK("ramp rate", (s == 0) ? 16'h010d : (s == 1) ? 16'h0100 : 16'h010c, lref)
      repeat (26) @(negedge ref_clk_i);
      `CHK("bounded reference", s[0] ? 16'h0110 : 16'h00fc, lref)
    end
    $display("test reference done");
    slave <= 1'b1;
    host.xfer(8'hd5, 1'b1, 16'h0003, rw, nk);
    `CHK("write nack", 1'b1, nk)
    host.xfer(8'hd4, 1'b0, 16'h0000, rw, nk);
    `CHK("read nack", 1'b1, nk)
    `CHK("refusal flags", 2'b11, {invalid_command_fault, alert})
    slave <= 1'b0;
    chk_rd(8'hd5, 16'h000f);
    $display("test loop slave done");
    summarize();
  end
endmodule : tb_top
bind rtm_regs rtm_regs_chk chk (.*);
